// >>> logic/ccs_clock_source_select.sv
// Purpose: primary oscillator mode decode, pin reuse, internal clock selection
// Assumes: oscillator inputs are far slower than pclk (at most half its rate)
// Notes:   oscillators are modelled as sampled edges; analog parts stay outside
`timescale 1ns/1ns

module ccs_clock_source_select #(
	parameter int unsigned START_TICKS = ccs_pkg::CCS_START_TICKS_DEF
) (
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// oscillator pins
	input  wire logic        crystal_in_pin_i,
	output logic             crystal_in_pin_o,
	output logic             crystal_in_pin_oe_n,
	input  wire logic        crystal_out_pin_i,
	output logic             crystal_out_pin_o,
	output logic             crystal_out_pin_oe_n,
	// port A side of the shared pins
	input  wire logic        porta_bit6_io_dout,
	input  wire logic        porta_bit6_io_oe_n,
	output logic             porta_bit6_io_din,
	input  wire logic        porta_bit7_io_dout,
	input  wire logic        porta_bit7_io_oe_n,
	output logic             porta_bit7_io_din,
	// internal oscillators
	input  wire logic        fast_osc_clk,
	input  wire logic        slow_osc_clk,
	output logic             fast_osc_en,
	output logic             slow_osc_en,
	output logic      [4:0]  trim_fast,
	output logic      [4:0]  trim_slow,
	// core side
	input  wire logic        in_sleep,
	output logic             mult_on,
	output logic             dev_tick,
	output logic             clk_ready
);
	import ccs_pkg::*;

	// refuse a start-up length the counter cannot hold
	if (START_TICKS == 0 || START_TICKS > 65535) begin : g_chk
		$error("START_TICKS out of range");
	end

	// software state
	logic [2:0]    fsel_q;
	logic          origin_q;
	logic          mult_en_q;
	logic [4:0]    trim_q;
	ccs_osc_mode_e mode_q;
	logic [3:0]    feat_q;
	// derived
	logic          setup;
	logic          wr_en;
	logic          clkout_m;
	logic          io6_m;
	logic          io7_m;
	logic          no_start_m;
	logic          mult_avail;
	logic          mult_want;
	logic          xin_lvl;
	logic          xin_rise;
	logic          xout_lvl;
	logic          fast_rise;
	logic          slow_rise;
	logic [7:0]    ps_q;
	logic          int_tick;
	logic          osc_tick;
	logic [1:0]    div_q;
	ccs_start_e    st_q;
	ccs_start_e    st_d;
	logic [15:0]   cnt_q;
	logic [15:0]   cnt_d;

	// true for an offset that holds a register
	function automatic logic mapped(input logic [11:0] a);
		return a == CCS_CTRL_OFS || a == CCS_TRIM_OFS || a == CCS_CFG_OFS || a == CCS_STAT_OFS;
	endfunction

	// low bits of the postscaler that must all be ones for a tap tick
	// the 31 kHz tap needs all eight bits, a shift alone stops at divide by 128
	function automatic logic [7:0] tap_mask(input logic [2:0] sel);
		if (sel == CCS_FSEL_31K) begin
			return 8'hFF;
		end
		return 8'hFF >> ({1'b0, sel} + 4'h1);
	endfunction

	// bus phases; the write lands at the completing edge only
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready & pwrite & mapped(paddr);

	// mode decode for pins, start-up and multiplier
	always_comb begin
		clkout_m   = 1'b0;
		io6_m      = 1'b0;
		io7_m      = 1'b0;
		no_start_m = 1'b1;
		unique case (mode_q)
			CCS_EXT_CLK_OUT:     clkout_m = 1'b1;
			CCS_EXT_CLK_PIN_IO:  io6_m    = 1'b1;
			CCS_RES_CAP_CLKOUT:  clkout_m = 1'b1;
			CCS_RES_CAP_PIN_IO:  io6_m    = 1'b1;
			CCS_INT_DIV4_PIN: begin
				clkout_m = 1'b1;
				io7_m    = 1'b1;
			end
			CCS_INT_DUAL_PIN_IO: begin
				io6_m = 1'b1;
				io7_m = 1'b1;
			end
			CCS_LOW_POWER_XTAL, CCS_STD_XTAL, CCS_HS_XTAL, CCS_HS_X4: no_start_m = 1'b0;
			// unused codes fall back to a plain crystal
			default:             no_start_m = 1'b0;
		endcase
	end

	// only at 4 or 8 MHz
	assign mult_avail = io7_m && (fsel_q == CCS_FSEL_8M || fsel_q == CCS_FSEL_4M);
	assign mult_want  = (mode_q == CCS_HS_X4) | (mult_en_q & mult_avail);

	// control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fsel_q   <= CCS_FSEL_RST;
			origin_q <= 1'b0;
			trim_q   <= CCS_TRIM_RST;
			mode_q   <= ccs_osc_mode_e'(CCS_MODE_RST);
			feat_q   <= CCS_FEAT_RST;
		end else if (wr_en) begin
			unique case (paddr)
				CCS_CTRL_OFS: fsel_q <= pwdata[CCS_FSEL_LSB +: 3];
				CCS_TRIM_OFS: begin
					origin_q <= pwdata[CCS_ORIGIN_BIT];
					// takes effect at once, no busy state
					trim_q   <= pwdata[4:0];
				end
				CCS_CFG_OFS: begin
					mode_q <= ccs_osc_mode_e'(pwdata[3:0]);
					feat_q <= pwdata[CCS_FEAT_LSB +: 4];
				end
				default: ;
			endcase
		end
	end

	// multiplier enable bit, cleared whenever it cannot act
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mult_en_q <= 1'b0;
		end else if (wr_en && paddr == CCS_TRIM_OFS) begin
			mult_en_q <= pwdata[CCS_MULT_BIT] & mult_avail;
		end else if (!mult_avail) begin
			mult_en_q <= 1'b0;
		end
	end

	// apb answer: one wait-free access phase, error on unmapped offsets
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~mapped(paddr);
			if (setup && !pwrite) begin
				unique case (paddr)
					CCS_CTRL_OFS: prdata <= {25'h0, fsel_q, 4'h0};
					CCS_TRIM_OFS: prdata <= {24'h0, origin_q, mult_en_q, 1'b0, trim_q};
					CCS_CFG_OFS:  prdata <= {20'h0, feat_q, 4'h0, mode_q};
					CCS_STAT_OFS: prdata <= {28'h0, clk_ready, mult_on, fast_osc_en, slow_osc_en};
					default:      prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// pin and oscillator synchronisers
	ccs_sync u_xin (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (crystal_in_pin_i),
		.lvl_q (xin_lvl),
		.rise  (xin_rise)
	);
	ccs_sync u_xout (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (crystal_out_pin_i),
		.lvl_q (xout_lvl),
		.rise  ()
	);
	ccs_sync u_fast (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (fast_osc_clk),
		.lvl_q (),
		.rise  (fast_rise)
	);
	ccs_sync u_slow (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (slow_osc_clk),
		.lvl_q (),
		.rise  (slow_rise)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ps_q <= 8'h00;
		end else if (fast_rise) begin
			ps_q <= ps_q + 8'h01;
		end
	end

	// origin bit decides at 31 kHz
	// divide by 256 or slow direct
	assign int_tick = (fsel_q == CCS_FSEL_31K && !origin_q) ? slow_rise
		: (fast_rise & (&(ps_q | ~tap_mask(fsel_q))));
	assign osc_tick = io7_m ? int_tick : xin_rise;

	// quarter-rate divider and device clock tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q    <= 2'h0;
			dev_tick <= 1'b0;
		end else begin
			dev_tick <= osc_tick;
			if (osc_tick) begin
				div_q <= div_q + 2'h1;
			end
		end
	end

	// switch only at a divider wrap, never mid-period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mult_on <= 1'b0;
		end else if (osc_tick && div_q == 2'h0) begin
			mult_on <= mult_want;
		end
	end

	// shared pin drivers; port data is same-domain so no sync
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crystal_out_pin_o    <= 1'b0;
			crystal_out_pin_oe_n <= 1'b1;
			crystal_in_pin_o     <= 1'b0;
			crystal_in_pin_oe_n  <= 1'b1;
			porta_bit6_io_din    <= 1'b0;
			porta_bit7_io_din    <= 1'b0;
		end else begin
			if (clkout_m) begin
				crystal_out_pin_o    <= div_q[1];
				crystal_out_pin_oe_n <= 1'b0;
			end else if (io6_m) begin
				crystal_out_pin_o    <= porta_bit6_io_dout;
				crystal_out_pin_oe_n <= porta_bit6_io_oe_n;
			end else begin
				crystal_out_pin_o    <= 1'b0;
				crystal_out_pin_oe_n <= 1'b1;
			end
			crystal_in_pin_o    <= io7_m & porta_bit7_io_dout;
			crystal_in_pin_oe_n <= io7_m ? porta_bit7_io_oe_n : 1'b1;
			porta_bit6_io_din   <= io6_m & xout_lvl;
			porta_bit7_io_din   <= io7_m & xin_lvl;
		end
	end

	// start-up sequencer
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		unique case (st_q)
			CCS_ST_HOLD: begin
				cnt_d = 16'h0000;
				// no wait for external clock modes
				if (!in_sleep) begin
					st_d = no_start_m ? CCS_ST_READY : CCS_ST_COUNT;
				end
			end
			CCS_ST_COUNT: begin
				if (in_sleep) begin
					st_d = CCS_ST_HOLD;
				end else if (xin_rise) begin
					if (cnt_q == 16'(START_TICKS - 1)) begin
						st_d = CCS_ST_READY;
					end
					cnt_d = cnt_q + 16'h0001;
				end
			end
			CCS_ST_READY: begin
				if (in_sleep) begin
					st_d = CCS_ST_HOLD;
				end
			end
			default: st_d = CCS_ST_HOLD;
		endcase
	end

	// sequencer flops and ready flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q      <= CCS_ST_HOLD;
			cnt_q     <= 16'h0000;
			clk_ready <= 1'b0;
		end else begin
			st_q      <= st_d;
			cnt_q     <= cnt_d;
			clk_ready <= (st_d == CCS_ST_READY);
		end
	end

	// oscillator enables and trim outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_osc_en <= 1'b1;
			slow_osc_en <= 1'b0;
			trim_fast   <= CCS_TRIM_RST;
			trim_slow   <= CCS_TRIM_RST;
		end else begin
			// on from 125 kHz up, or as 31.25 kHz source
			fast_osc_en <= (fsel_q != CCS_FSEL_31K) | origin_q;
			// selected or needed by a timer feature
			slow_osc_en <= (io7_m & fsel_q == CCS_FSEL_31K & ~origin_q) | (|feat_q);
			// signed code passed unchanged to the tuner
			trim_fast   <= trim_q;
			// slow side picks it up at its next edge
			if (slow_rise) begin
				trim_slow <= trim_q;
			end
		end
	end

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence trim_wr_s;
		wr_en && paddr == CCS_TRIM_OFS;
	endsequence

	mult_forced_a: assert property (trim_wr_s ##0 !mult_avail |=> !mult_en_q)
		else $error("multiplier enable stored while unavailable");
	mult_gate_a: assert property (mult_en_q |-> $past(mult_avail))
		else $error("multiplier enable held outside allowed setting");
	ext_ready_a: assert property (no_start_m && !in_sleep && st_q == CCS_ST_HOLD |=> clk_ready)
		else $error("external clock mode waited for start-up");
	clkout_drive_a: assert property (clkout_m && $past(clkout_m) |-> !crystal_out_pin_oe_n)
		else $error("clock output pin not driven");
	div4_edge_a: assert property ($changed(div_q[1]) |-> $past(osc_tick && div_q[0]))
		else $error("divide by four output moved off its edge");
	pin6_io_a: assert property (io6_m && $past(io6_m) |-> crystal_out_pin_o == $past(porta_bit6_io_dout))
		else $error("bit 6 data not on out pin");
	pin7_io_a: assert property (io7_m ##1 io7_m |-> porta_bit7_io_din == $past(xin_lvl))
		else $error("bit 7 input not returned");
	fast_en_a: assert property (fsel_q != CCS_FSEL_31K |=> fast_osc_en)
		else $error("fast oscillator off in its range");
	slow_en_a: assert property (|feat_q |=> slow_osc_en)
		else $error("slow oscillator off with a feature on");
	mult_switch_a: assert property ($changed(mult_on) |-> $past(osc_tick && div_q == 2'h0))
		else $error("multiplier switched mid period");
	div256_a: assert property (io7_m && fsel_q == CCS_FSEL_31K && origin_q |=> dev_tick == $past(fast_rise && ps_q == 8'hFF))
		else $error("divide by 256 tick missing");
endmodule

// >>> logic/ccs_pkg.sv
// Purpose: shared constants and types of the clock source selector
// Assumes: 32-bit APB register map, one word per register
// Notes:   mode codes other than the multiplier and internal ones are local picks
package ccs_pkg;

	// primary oscillator mode codes
	typedef enum logic [3:0] {
		CCS_LOW_POWER_XTAL  = 4'h0,
		CCS_STD_XTAL        = 4'h1,
		CCS_HS_XTAL         = 4'h2,
		CCS_RES_CAP_CLKOUT  = 4'h3,
		CCS_EXT_CLK_OUT     = 4'h4,
		CCS_EXT_CLK_PIN_IO  = 4'h5,
		CCS_HS_X4           = 4'h6,
		CCS_RES_CAP_PIN_IO  = 4'h7,
		CCS_INT_DUAL_PIN_IO = 4'h8,
		CCS_INT_DIV4_PIN    = 4'h9
	} ccs_osc_mode_e;

	// start-up sequencer states
	typedef enum logic [1:0] {
		CCS_ST_HOLD  = 2'b00,
		CCS_ST_COUNT = 2'b01,
		CCS_ST_READY = 2'b10
	} ccs_start_e;

	// register byte offsets
	localparam logic [11:0] CCS_CTRL_OFS = 12'h000;
	localparam logic [11:0] CCS_TRIM_OFS = 12'h004;
	localparam logic [11:0] CCS_CFG_OFS  = 12'h008;
	localparam logic [11:0] CCS_STAT_OFS = 12'h00C;

	// field positions
	localparam int CCS_FSEL_LSB   = 4;
	localparam int CCS_ORIGIN_BIT = 7;
	localparam int CCS_MULT_BIT   = 6;
	localparam int CCS_FEAT_LSB   = 8;

	// frequency select codes
	localparam logic [2:0] CCS_FSEL_31K = 3'h0;
	localparam logic [2:0] CCS_FSEL_1M  = 3'h4;
	localparam logic [2:0] CCS_FSEL_4M  = 3'h6;
	localparam logic [2:0] CCS_FSEL_8M  = 3'h7;

	// reset values
	localparam logic [2:0] CCS_FSEL_RST  = CCS_FSEL_1M;
	localparam logic [4:0] CCS_TRIM_RST  = 5'h00;
	localparam logic [3:0] CCS_MODE_RST  = 4'h2;
	localparam logic [3:0] CCS_FEAT_RST  = 4'h0;

	// crystal start-up length in oscillator edges
	localparam int CCS_START_TICKS_DEF = 1024;

endpackage

// >>> logic/ccs_sync.sv
// Purpose: two-stage synchroniser with rising edge pulse
// Assumes: d is asynchronous to clk
// Notes:   only the second stage feeds the edge detector
`timescale 1ns/1ns
module ccs_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// asynchronous level
	input  wire logic d,
	// synchronised level and its rising edge
	output logic      lvl_q,
	output logic      rise
);
	logic       meta_q;
	logic       prev_q;
	logic [2:0] arm_q;

	// two flops, then one more for the edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			lvl_q  <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= d;
			lvl_q  <= meta_q;
			prev_q <= lvl_q;
		end
	end

	// edge detect armed only once all three flops hold the pin, not reset zeros
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arm_q <= 3'h0;
		end else begin
			arm_q <= {arm_q[1:0], 1'b1};
		end
	end

	// one-cycle pulse per low-to-high edge; a pin idling high gives no false edge
	assign rise = lvl_q & ~prev_q & arm_q[2];
endmodule

// >>> bench/ccs_osc_model.sv
// Purpose: far side of the oscillator pins plus the two internal oscillators
// Assumes: the in pin carries a pull-up when nobody drives it; the undriven out pin follows ext_lvl
// Notes:   disabled oscillators stand at 0 so no stale edge reaches the block
`timescale 1ns/1ns
module ccs_osc_model (
	// design drive of the two pins
	input  wire logic in_o,
	input  wire logic in_oe_n,
	input  wire logic out_o,
	input  wire logic out_oe_n,
	// bench controls
	input  wire logic run_xtal,
	input  wire logic ext_lvl,
	input  wire logic fast_en,
	input  wire logic slow_en,
	// resolved pins and oscillator waves
	output logic      in_i,
	output logic      out_i,
	output logic      fast_clk,
	output logic      slow_clk
);
	logic xtal = 1'b0;
	logic fast = 1'b0;
	logic slow = 1'b0;

	// free-running sources, all well below half of pclk
	always #500 xtal = ~xtal;
	always #400 fast = ~fast;
	always #1500 slow = ~slow;

	// pin levels: design drive wins, else source or pull-up
	assign in_i     = !in_oe_n ? in_o : (run_xtal ? xtal : 1'b1);
	assign out_i    = !out_oe_n ? out_o : ext_lvl;
	assign fast_clk = fast_en & fast;
	assign slow_clk = slow_en & slow;
endmodule

// >>> bench/clock_source_select_bench.sv
// Purpose: self-checking bench of the clock source selector
// Assumes: apb answers with zero wait states but is polled anyway
// Notes:   start-up count shortened to 4 oscillator edges
`timescale 1ns/1ns
module clock_source_select_bench;
	import ccs_pkg::*;

	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        in_i, in_o, in_oe_n, out_i, out_o, out_oe_n;
	logic        p6_dout = 1'b0;
	logic        p6_oe_n = 1'b1;
	logic        p7_dout = 1'b0;
	logic        p7_oe_n = 1'b1;
	logic        p6_din, p7_din, fast_clk, slow_clk, fast_en, slow_en;
	logic [4:0]  trim_fast, trim_slow;
	logic        in_sleep = 1'b0;
	logic        run_xtal = 1'b1;
	logic        ext_lvl = 1'b0;
	logic        mult_on, clk_ready, dev_tick;
	int          bad_count = 0;
	int          cmp_count = 0;

	// clock, 100 ns period
	always #50 pclk = ~pclk;

	ccs_clock_source_select #(.START_TICKS(4)) u_ccs_clock_source_select (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.crystal_in_pin_i(in_i), .crystal_in_pin_o(in_o), .crystal_in_pin_oe_n(in_oe_n),
		.crystal_out_pin_i(out_i), .crystal_out_pin_o(out_o), .crystal_out_pin_oe_n(out_oe_n),
		.porta_bit6_io_dout(p6_dout), .porta_bit6_io_oe_n(p6_oe_n), .porta_bit6_io_din(p6_din),
		.porta_bit7_io_dout(p7_dout), .porta_bit7_io_oe_n(p7_oe_n), .porta_bit7_io_din(p7_din),
		.fast_osc_clk(fast_clk), .slow_osc_clk(slow_clk), .fast_osc_en(fast_en),
		.slow_osc_en(slow_en), .trim_fast(trim_fast), .trim_slow(trim_slow),
		.in_sleep(in_sleep), .mult_on(mult_on), .dev_tick(dev_tick), .clk_ready(clk_ready)
	);

	ccs_osc_model u_ccs_osc_model (
		.in_o(in_o), .in_oe_n(in_oe_n), .out_o(out_o), .out_oe_n(out_oe_n),
		.run_xtal(run_xtal), .ext_lvl(ext_lvl), .fast_en(fast_en), .slow_en(slow_en),
		.in_i(in_i), .out_i(out_i), .fast_clk(fast_clk), .slow_clk(slow_clk)
	);

	// verdict and end of run
	task automatic close_out();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one apb transfer, entered right after a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only pready or the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge so a following call never rewrites psel in this time step
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x, input string nm);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(nm, x, r & m);
	endtask

	function automatic logic [4:0] pick(input int s);
		case (s)
			0: return {4'h0, mult_on};
			1: return {4'h0, clk_ready};
			2: return {4'h0, slow_en};
			3: return {4'h0, fast_en};
			4: return {4'h0, p6_din};
			5: return {4'h0, out_oe_n};
			6: return {4'h0, in_oe_n};
			7: return {4'h0, out_o};
			8: return trim_fast;
			9: return trim_slow;
			default: return {4'h0, p7_din};
		endcase
	endfunction

	// poll an output under a bound, then compare
	task automatic wait_chk(input int s, input logic [4:0] v, input string nm);
		for (int k = 0; k < 600 && pick(s) !== v; k++) begin
			@(posedge pclk);
		end
		chk(nm, {27'h0, v}, {27'h0, pick(s)});
	endtask

	task automatic sleep_pulse();
		in_sleep <= 1'b1;
		@(posedge pclk);
		in_sleep <= 1'b0;
	endtask

	task automatic t_reset();
		logic [31:0] r;
		logic        e;
		rd_chk(CCS_CTRL_OFS, 32'h70, {25'h0, CCS_FSEL_RST, 4'h0}, "freq select");
		rd_chk(CCS_STAT_OFS, 32'h3, 32'h2, "osc enables");
		apb(1'b0, 12'h010, 32'h0, r, e);
		chk("unmapped data", 32'h0, r);
		chk("unmapped error", 32'h1, {31'h0, e});
	endtask

	// crystal mode needs edges after wake, external clock does not
	task automatic t_start();
		run_xtal <= 1'b0;
		sleep_pulse();
		repeat (30) @(posedge pclk);
		chk("xtal held", 32'h0, {31'h0, clk_ready});
		run_xtal <= 1'b1;
		wait_chk(1, 5'h1, "xtal ready");
		wr(CCS_CFG_OFS, 32'h4);
		run_xtal <= 1'b0;
		sleep_pulse();
		repeat (3) @(posedge pclk);
		chk("ext ready", 32'h1, {31'h0, clk_ready});
		run_xtal <= 1'b1;
	endtask

	// out pin driven only in the clock-output modes
	task automatic t_pins();
		logic [3:0] md [6] = '{4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9};
		logic       oe [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
		for (int i = 0; i < 6; i++) begin
			wr(CCS_CFG_OFS, {28'h0, md[i]});
			wait_chk(5, {4'h0, oe[i]}, "out pin oe_n");
		end
	endtask

	// source rising edges between two out-pin rising edges
	task automatic t_div4(input logic [3:0] md, input logic use_fast);
		int   orise;
		int   irise;
		int   trise;
		logic po;
		logic pi;
		logic ci;
		orise = 0;
		irise = 0;
		trise = 0;
		wr(CCS_CFG_OFS, {28'h0, md});
		wr(CCS_CTRL_OFS, 32'h70);
		repeat (50) @(posedge pclk);
		po = out_o;
		pi = use_fast ? fast_clk : in_i;
		for (int k = 0; k < 2000 && orise < 2; k++) begin
			@(posedge pclk);
			ci = use_fast ? fast_clk : in_i;
			if (ci && !pi && orise == 1) irise++;
			if (dev_tick && orise == 1) trise++;
			if (out_o && !po) orise++;
			po = out_o;
			pi = ci;
		end
		chk("div4 edges", 32'h4, irise);
		chk("div4 ticks", 32'h4, trise);
	endtask

	// fast source edges between two device ticks on the 31.25 kHz tap
	task automatic t_div256();
		int   n;
		int   t;
		logic pf;
		n = 0;
		t = 0;
		wr(CCS_CFG_OFS, 32'h8);
		wr(CCS_CTRL_OFS, 32'h0);
		wr(CCS_TRIM_OFS, 32'h80);
		pf = fast_clk;
		for (int k = 0; k < 6000 && t < 2; k++) begin
			@(posedge pclk);
			if (fast_clk && !pf && t == 1) n++;
			if (dev_tick) t++;
			pf = fast_clk;
		end
		chk("div256 edges", 32'h100, n);
	endtask

	// freed pins pass port data both ways
	task automatic t_io();
		wr(CCS_CFG_OFS, 32'h5);
		ext_lvl <= 1'b1;
		wait_chk(4, 5'h1, "bit6 in high");
		ext_lvl <= 1'b0;
		wait_chk(4, 5'h0, "bit6 in low");
		wr(CCS_CFG_OFS, 32'h7);
		ext_lvl <= 1'b1;
		wait_chk(4, 5'h1, "rc bit6 in");
		wr(CCS_CFG_OFS, 32'h8);
		p7_oe_n <= 1'b0;
		p7_dout <= 1'b1;
		p6_oe_n <= 1'b0;
		p6_dout <= 1'b1;
		wait_chk(6, 5'h0, "bit7 drive");
		wait_chk(7, 5'h1, "bit6 out");
		wait_chk(10, 5'h1, "bit7 in high");
		p7_dout <= 1'b0;
		wait_chk(10, 5'h0, "bit7 in low");
		p7_oe_n <= 1'b1;
		p6_oe_n <= 1'b1;
	endtask

	task automatic t_mult();
		wr(CCS_CFG_OFS, 32'h6);
		wait_chk(0, 5'h1, "hs x4 on");
		wr(CCS_CFG_OFS, 32'h2);
		wait_chk(0, 5'h0, "hs x4 off");
		wr(CCS_CFG_OFS, 32'h9);
		wr(CCS_CTRL_OFS, 32'h70);
		wr(CCS_TRIM_OFS, 32'h40);
		rd_chk(CCS_TRIM_OFS, 32'h40, 32'h40, "mult bit");
		wait_chk(0, 5'h1, "int x4 on");
		wr(CCS_CTRL_OFS, 32'h40);
		wait_chk(0, 5'h0, "int x4 1m");
		rd_chk(CCS_TRIM_OFS, 32'h40, 32'h0, "mult cleared");
		wr(CCS_CFG_OFS, 32'h8);
		wr(CCS_CTRL_OFS, 32'h60);
		wr(CCS_TRIM_OFS, 32'h40);
		wait_chk(0, 5'h1, "dual x4 on");
		wr(CCS_CFG_OFS, 32'h4);
		wait_chk(0, 5'h0, "ext x4 off");
		wr(CCS_TRIM_OFS, 32'h40);
		rd_chk(CCS_TRIM_OFS, 32'h40, 32'h0, "mult forced");
	endtask

	task automatic t_slow();
		wr(CCS_CFG_OFS, 32'h402);
		wait_chk(2, 5'h1, "slow by feature");
		wr(CCS_CFG_OFS, 32'h8);
		wr(CCS_CTRL_OFS, 32'h0);
		wr(CCS_TRIM_OFS, 32'h0);
		wait_chk(2, 5'h1, "slow origin");
		wait_chk(3, 5'h0, "fast idle");
		wr(CCS_TRIM_OFS, 32'h80);
		wait_chk(3, 5'h1, "fast origin");
		wr(CCS_TRIM_OFS, 32'h0);
		wr(CCS_CTRL_OFS, 32'h20);
		wait_chk(3, 5'h1, "fast 250k");
	endtask

	// retune keeps running and raises no flag
	task automatic t_trim();
		logic [4:0] tv [2] = '{5'h0F, 5'h10};
		wr(CCS_CFG_OFS, 32'h404);
		for (int i = 0; i < 2; i++) begin
			wr(CCS_TRIM_OFS, {27'h0, tv[i]});
			rd_chk(CCS_TRIM_OFS, 32'hBF, {27'h0, tv[i]}, "trim read");
			wait_chk(8, tv[i], "trim fast");
			wait_chk(9, tv[i], "trim slow");
			chk("ready kept", 32'h1, {31'h0, clk_ready});
		end
	endtask

	// watchdog against a hung handshake or poll
	initial begin
		#(100 * 60000);
		bad_count++;
		close_out();
	end

	// main sequence
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		wait_chk(1, 5'h1, "first ready");
		t_start();
		t_pins();
		t_div4(4'h4, 1'b0);
		t_div4(4'h3, 1'b0);
		t_div4(4'h9, 1'b1);
		t_io();
		t_mult();
		t_slow();
		t_div256();
		t_trim();
		close_out();
	end
endmodule
